/* File: core/irq_pkg.sv */
// Constants and carriers for the metering interrupt status and mask block
package irq_pkg;

  // ----------------------------------------
  // Register indices, reset values and read default
  // ----------------------------------------
  localparam logic [11:0] STAT_IDX = 12'h402;
  localparam logic [11:0] MASK_IDX = 12'h405;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] RD_NONE  = 32'h0000_0000;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam logic [15:0] STAT_DEF_BITS = 16'hfff5;
  localparam logic [31:0] MASK_WR_BITS  = 32'h63b0_fff5;
  localparam int          FLAG_W        = 16;
  localparam int          B_AREV        = 0;
  localparam int          B_RREV        = 2;
  localparam int          B_REV1        = 4;
  localparam int          B_REV2        = 5;
  localparam int          B_PLS1        = 6;
  localparam int          B_PLS2        = 7;
  localparam int          B_EGY         = 8;
  localparam int          B_WAV         = 9;
  localparam int          B_PWR         = 10;
  localparam int          B_RMS         = 11;
  localparam int          B_TMP         = 12;
  localparam int          B_ANL         = 13;
  localparam int          B_VNL         = 14;
  localparam int          B_RNL         = 15;
  localparam int          MB_CHIP_SUM   = 31;
  localparam int          MB_EVENT_SUM  = 30;
  localparam int          MB_CAL_SUM    = 29;
  localparam int          MB_PF_READY   = 25;
  localparam int          MB_CSUM_CHG   = 24;
  localparam int          MB_CSUM_DONE  = 23;
  localparam int          MB_VCROSS_TMO = 21;
  localparam int          MB_ICROSS_B   = 20;

  // ----------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic reactive_noload_flag;
    logic apparent_noload_flag;
    logic active_noload_flag;
    logic temp_ready;
    logic rms_offset_ready_flag;
    logic power_ready_flag;
    logic waveform_ready_flag;
    logic energy_ready_flag;
  } metro_evt_t;

  typedef struct packed {
    logic active_neg;
    logic reactive_neg;
  } power_sign_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR   = 2'b01,
    BUS_RDLD = 2'b10,
    BUS_RDOUT = 2'b11
  } bus_st_t;

  function automatic logic [31:0] byte_addr(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction

endpackage

/* File: core/pulse_flip_detect.sv */
// Energy pulse pin falling edge and sign reversal detector
`timescale 1ns/100ps
module pulse_flip_detect
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Pin and pulse sign
  input  wire logic pin_i,
  input  wire logic neg_i,
  // Events
  output logic      pulse_o,
  output logic      flip_o
);

  // ----------------------------------------
  // Synchroniser and edge
  // ----------------------------------------
  logic sync1_r, sync2_r, last_r, prev_neg_r, seen_r, pulse_r, flip_r;
  logic seen_nxt, prev_neg_nxt, pulse_nxt, flip_nxt, fall;

  always_comb begin
    fall         = last_r & ~sync2_r;
    pulse_nxt    = fall;
    flip_nxt     = fall & seen_r & (neg_i != prev_neg_r);
    seen_nxt     = seen_r | fall;
    prev_neg_nxt = fall ? neg_i : prev_neg_r;
  end

  // High idle level assumed so reset does not fake a pulse
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      last_r     <= 1'b1;
      seen_r     <= 1'b0;
      prev_neg_r <= 1'b0;
      pulse_r    <= 1'b0;
      flip_r     <= 1'b0;
    end else begin
      sync1_r    <= pin_i;
      sync2_r    <= sync1_r;
      last_r     <= sync2_r;
      seen_r     <= seen_nxt;
      prev_neg_r <= prev_neg_nxt;
      pulse_r    <= pulse_nxt;
      flip_r     <= flip_nxt;
    end
  end

  assign pulse_o = pulse_r;
  assign flip_o  = flip_r;

  a_flip_at_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
    flip_o |-> pulse_o) else $error("Sign flip without a pulse");

endmodule

/* File: core/sign_flip_detect.sv */
// Power sign reversal detector sampled at each power refresh
`timescale 1ns/100ps
module sign_flip_detect
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Refresh and sign
  input  wire logic refresh_i,
  input  wire logic neg_i,
  // Event
  output logic      flip_o
);

  // ----------------------------------------
  // Sign history
  // ----------------------------------------
  logic prev_r, seen_r, prev_nxt, seen_nxt, flip_nxt;

  always_comb begin
    flip_nxt = refresh_i & seen_r & (neg_i != prev_r);
    prev_nxt = refresh_i ? neg_i : prev_r;
    seen_nxt = seen_r | refresh_i;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      seen_r <= seen_nxt;
    end
  end

  // Combinational so the flag lands with the refresh flag
  assign flip_o = flip_nxt;

endmodule

/* File: core/metering_irq_status_mask.sv */
// Interrupt status and mask registers of the metering core, AHB-Lite slave
`timescale 1ns/100ps
module metering_irq_status_mask
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Metrology events, one-cycle pulses
  input  wire metro_evt_t  evt_i,
  input  wire power_sign_t power_sign_i,
  // Energy pulse pins and their signs
  input  wire logic        first_pulse_output_i,
  input  wire logic        first_pulse_neg_i,
  input  wire logic        second_pulse_output_i,
  input  wire logic        second_pulse_neg_i,
  // Upper status half from neighbouring logic
  input  wire logic [15:0] status_hi_i,
  // Interrupt request
  output logic             irq_o
);

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic pls1, flip1, pls2, flip2, rflip, aflip;

  // Pin crosses into mclk_i inside, sign checked only at the fall
  pulse_flip_detect u_first (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   (first_pulse_output_i),
    .neg_i   (first_pulse_neg_i),
    .pulse_o (pls1),
    .flip_o  (flip1)
  );

  pulse_flip_detect u_second (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   (second_pulse_output_i),
    .neg_i   (second_pulse_neg_i),
    .pulse_o (pls2),
    .flip_o  (flip2)
  );

  sign_flip_detect u_reactive (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .refresh_i (evt_i.power_ready_flag),
    .neg_i     (power_sign_i.reactive_neg),
    .flip_o    (rflip)
  );

  sign_flip_detect u_active (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .refresh_i (evt_i.power_ready_flag),
    .neg_i     (power_sign_i.active_neg),
    .flip_o    (aflip)
  );

  // ----------------------------------------
  // Event vector
  // ----------------------------------------
  logic [FLAG_W-1:0] set_vec;

  always_comb begin
    set_vec         = '0;
    set_vec[B_RNL]  = evt_i.reactive_noload_flag;
    set_vec[B_VNL]  = evt_i.apparent_noload_flag;
    set_vec[B_ANL]  = evt_i.active_noload_flag;
    set_vec[B_TMP]  = evt_i.temp_ready;
    set_vec[B_RMS]  = evt_i.rms_offset_ready_flag;
    set_vec[B_PWR]  = evt_i.power_ready_flag;
    set_vec[B_WAV]  = evt_i.waveform_ready_flag;
    set_vec[B_EGY]  = evt_i.energy_ready_flag;
    set_vec[B_PLS2] = pls2;
    set_vec[B_PLS1] = pls1;
    set_vec[B_REV2] = flip2;
    set_vec[B_REV1] = flip1;
    set_vec[B_RREV] = rflip;
    set_vec[B_AREV] = aflip;
  end

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  bus_st_t     st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        take;

  // Reads take one wait state so the data comes from a flop and
  // always sees a write made in the cycle before
  always_comb begin
    take     = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
    st_nxt   = st_r;
    addr_nxt = addr_r;
    case (st_r)
      BUS_RDLD: begin
        st_nxt = BUS_RDOUT;
      end
      default: begin
        if (take) begin
          addr_nxt = haddr_i;
          st_nxt   = hwrite_i ? BUS_WR : BUS_RDLD;
        end else if (hready_i) begin
          st_nxt = BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r   <= BUS_IDLE;
      addr_r <= '0;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------
  // Status and mask registers
  // ----------------------------------------
  logic [FLAG_W-1:0] stat_r, stat_nxt, clr_vec;
  logic [31:0]       mask_r, mask_nxt, stat_full;
  logic              wr_stat, wr_mask, irq_r, irq_nxt;

  always_comb begin
    wr_stat   = (st_r == BUS_WR) && (addr_r == byte_addr(STAT_IDX));
    wr_mask   = (st_r == BUS_WR) && (addr_r == byte_addr(MASK_IDX));
    clr_vec   = wr_stat ? hwdata_i[FLAG_W-1:0] : '0;
    // Set after clear so a fresh event survives the clear
    stat_nxt  = ((stat_r & ~clr_vec) | set_vec) & STAT_DEF_BITS;
    mask_nxt  = mask_r;
    if (wr_mask) begin
      mask_nxt = hwdata_i & MASK_WR_BITS;
    end
    stat_full = {status_hi_i, stat_r};
    // Bits 19..16 have no mask, so they never reach it
    irq_nxt   = |(stat_full & mask_r);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stat_r <= STAT_RST[FLAG_W-1:0];
      mask_r <= MASK_RST;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (st_r == BUS_RDLD) begin
      if (addr_r == byte_addr(STAT_IDX)) begin
        rdata_nxt = stat_full;
      end else if (addr_r == byte_addr(MASK_IDX)) begin
        rdata_nxt = mask_r;
      end else begin
        rdata_nxt = RD_NONE;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_r <= RD_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata_o    = rdata_r;
  assign hreadyout_o = (st_r != BUS_RDLD);
  assign hresp_o     = HRESP_OKAY;
  assign irq_o       = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_noload_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.reactive_noload_flag |=> stat_r[B_RNL])
    else $error("Reactive noload flag not set");

  a_power_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.power_ready_flag |=> stat_r[B_PWR])
    else $error("Power ready flag not set");

  a_pulse_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(u_first.sync2_r) |-> ##2 stat_r[B_PLS1])
    else $error("First pulse flag missed a falling edge");

  a_rev_only_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(stat_r[B_REV2]) |-> $past(pls2))
    else $error("Second pulse sign flag set without a pulse");

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    (stat_r & ~STAT_DEF_BITS) == '0 && mask_r[MB_CHIP_SUM] == 1'b0)
    else $error("Reserved bit became set");

  a_mask_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_mask |=> mask_r[MB_PF_READY] == $past(hwdata_i[MB_PF_READY]))
    else $error("Mask write not stored");

  a_w1c_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_stat && hwdata_i[B_TMP] && !evt_i.temp_ready |=> !stat_r[B_TMP])
    else $error("Write one did not clear flag");

  a_set_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_stat && hwdata_i[B_WAV] && evt_i.waveform_ready_flag |=> stat_r[B_WAV])
    else $error("Event lost during clear");

  a_irq_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 irq_o == $past(|({status_hi_i, stat_r} & mask_r)))
    else $error("Interrupt does not follow flags and mask");

  a_read_wait: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("Read wait state wrong");

  a_apparent_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.apparent_noload_flag |=> stat_r[B_VNL])
    else $error("Apparent noload flag not set");

  a_active_nl_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.active_noload_flag |=> stat_r[B_ANL])
    else $error("Active noload flag not set");

  a_temp_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.temp_ready |=> stat_r[B_TMP])
    else $error("Temperature flag not set");

  a_rms_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.rms_offset_ready_flag |=> stat_r[B_RMS])
    else $error("Rms offset flag not set");

  a_wave_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.waveform_ready_flag |=> stat_r[B_WAV])
    else $error("Waveform flag not set");

  a_energy_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    evt_i.energy_ready_flag |=> stat_r[B_EGY])
    else $error("Energy flag not set");

  a_pulse2_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(u_second.sync2_r) |-> ##2 stat_r[B_PLS2])
    else $error("Second pulse flag missed a falling edge");

  a_flip2_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    flip2 |=> stat_r[B_REV2])
    else $error("Second pulse sign flag not set");

  a_flip1_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    flip1 |=> stat_r[B_REV1])
    else $error("First pulse sign flag not set");

  a_rev1_only_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(stat_r[B_REV1]) |-> $past(pls1))
    else $error("First pulse sign flag set without a pulse");

  a_rflip_refresh: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(stat_r[B_RREV]) |-> $past(evt_i.power_ready_flag))
    else $error("Reactive sign flag set outside a refresh");

  a_aflip_refresh: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(stat_r[B_AREV]) |-> $past(evt_i.power_ready_flag))
    else $error("Active sign flag set outside a refresh");

  a_flags_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    !wr_stat |=> ($past(stat_r) & ~stat_r) == '0)
    else $error("Flag dropped without a clear");

  a_mask_reserved: assert property (@(posedge mclk_i) disable iff (reset_i)
    (mask_r & ~MASK_WR_BITS) == '0)
    else $error("Reserved mask bit became set");

  a_event_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_EVENT_SUM] && mask_r[MB_EVENT_SUM] |=> irq_o)
    else $error("Event summary did not interrupt");

  a_pf_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_PF_READY] && mask_r[MB_PF_READY] |=> irq_o)
    else $error("Power factor ready did not interrupt");

  a_csum_chg_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_CSUM_CHG] && mask_r[MB_CSUM_CHG] |=> irq_o)
    else $error("Checksum change did not interrupt");

  a_csum_done_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_CSUM_DONE] && mask_r[MB_CSUM_DONE] |=> irq_o)
    else $error("Checksum done did not interrupt");

  a_vcross_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_VCROSS_TMO] && mask_r[MB_VCROSS_TMO] |=> irq_o)
    else $error("Voltage crossing timeout did not interrupt");

  a_icross_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_full[MB_ICROSS_B] && mask_r[MB_ICROSS_B] |=> irq_o)
    else $error("Current B crossing did not interrupt");

  a_irq_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
    (stat_full & mask_r) == '0 |=> !irq_o)
    else $error("Interrupt without an enabled flag");

endmodule

/* File: testbench/testbench.sv */
// Self-checking testbench for the metering interrupt status and mask block
`timescale 1ns/100ps
module testbench;
  import irq_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [31:0] STAT_A = {18'h0, STAT_IDX, 2'b00};
  localparam logic [31:0] MASK_A = {18'h0, MASK_IDX, 2'b00};
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  metro_evt_t  evt = '0;
  power_sign_t psign = '0;
  logic        p1 = 1'b1;
  logic        n1 = 1'b0;
  logic        p2 = 1'b1;
  logic        n2 = 1'b0;
  logic [15:0] shi = 16'h0;
  logic        irq;
  int          bad_count = 0;
  int          num_checks = 0;

  always #4 mclk = ~mclk;

  metering_irq_status_mask dut (
    .mclk_i(mclk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hready_i(hreadyout), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .evt_i(evt),
    .power_sign_i(psign), .first_pulse_output_i(p1), .first_pulse_neg_i(n1),
    .second_pulse_output_i(p2), .second_pulse_neg_i(n2), .status_hi_i(shi), .irq_o(irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Ready is stable between edges, so it is looked at on the falling edge
  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge mclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      $display("[FAIL] hready expected 1 seen %b", hreadyout);
    end
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    @(posedge mclk);
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d, input metro_evt_t e);
    logic [31:0] v;
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    wait_rdy(v);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    evt    <= e;
    wait_rdy(v);
    evt    <= '0;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= 1'b0;
    htrans <= HTRANS_NONSEQ;
    wait_rdy(v);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    wait_rdy(v);
    chk(what, v, exp);
  endtask

  task automatic ev_pulse(input metro_evt_t e, input power_sign_t s);
    @(posedge mclk);
    evt   <= e;
    psign <= s;
    @(posedge mclk);
    evt   <= '0;
  endtask

  // Pin held low long enough to pass the synchroniser, sign kept as a level
  task automatic pin_pulse(input bit sec, input logic neg);
    @(posedge mclk);
    if (sec) begin
      p2 <= 1'b0;
      n2 <= neg;
    end else begin
      p1 <= 1'b0;
      n1 <= neg;
    end
    repeat (4) @(posedge mclk);
    p1 <= 1'b1;
    p2 <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk("status reset", STAT_A, STAT_RST);
    rd_chk("mask reset", MASK_A, MASK_RST);
    rd_chk("unmapped read", 32'h1000, RD_NONE);
    bus_wr(MASK_A, 32'hffff_ffff, '0);
    bus_wr(32'h1004, 32'h0, '0);
    rd_chk("mask writable", MASK_A, 32'h63b0_fff5);
    bus_wr(MASK_A, 32'h0, '0);
    rd_chk("mask clear", MASK_A, 32'h0);
  endtask

  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      ev_pulse(metro_evt_t'(8'h01 << i), '0);
      rd_chk("event flag", STAT_A, 32'h1 << (8 + i));
      bus_wr(STAT_A, 32'hffff_0000, '0);
      rd_chk("write zero keeps", STAT_A, 32'h1 << (8 + i));
      bus_wr(STAT_A, 32'h1 << (8 + i), '0);
      rd_chk("write one clears", STAT_A, 32'h0);
    end
    ev_pulse(metro_evt_t'(8'h10), '0);
    bus_wr(STAT_A, 32'h0000_1000, metro_evt_t'(8'h10));
    rd_chk("event beats clear", STAT_A, 32'h0000_1000);
    bus_wr(STAT_A, 32'h0000_1000, '0);
  endtask

  task automatic t_power;
    ev_pulse(metro_evt_t'(8'h04), 2'b11);
    rd_chk("both signs flip", STAT_A, 32'h0000_0405);
    bus_wr(STAT_A, 32'h0000_ffff, '0);
    ev_pulse(metro_evt_t'(8'h04), 2'b10);
    rd_chk("reactive flip only", STAT_A, 32'h0000_0404);
    bus_wr(STAT_A, 32'h0000_ffff, '0);
  endtask

  task automatic t_pins;
    for (int s = 0; s < 2; s++) begin
      pin_pulse(s[0], 1'b0);
      pin_pulse(s[0], 1'b0);
      rd_chk("pulse no flip", STAT_A, 32'h40 << s);
      bus_wr(STAT_A, 32'h0000_ffff, '0);
      @(posedge mclk);
      if (s == 0) n1 <= 1'b1;
      else n2 <= 1'b1;
      repeat (8) @(posedge mclk);
      rd_chk("sign without pulse", STAT_A, 32'h0);
      pin_pulse(s[0], 1'b1);
      rd_chk("pulse with flip", STAT_A, 32'h50 << s);
      bus_wr(STAT_A, 32'h0000_ffff, '0);
    end
  endtask

  task automatic t_irq;
    bus_wr(MASK_A, 32'h0000_0040, '0);
    pin_pulse(1'b0, 1'b1);
    chk("irq on flag", {31'h0, irq}, 32'h1);
    bus_wr(STAT_A, 32'h0000_0040, '0);
    repeat (2) @(negedge mclk);
    chk("irq after clear", {31'h0, irq}, 32'h0);
    pin_pulse(1'b0, 1'b1);
    bus_wr(MASK_A, 32'h0000_0000, '0);
    repeat (2) @(negedge mclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus_wr(STAT_A, 32'h0000_0040, '0);
    bus_wr(MASK_A, 32'hffff_ffff, '0);
    shi <= 16'h8000;
    rd_chk("upper half read", STAT_A, 32'h8000_0000);
    chk("chip summary no irq", {31'h0, irq}, 32'h0);
    shi <= 16'h2000;
    bus_wr(STAT_A, 32'hffff_0000, '0);
    rd_chk("upper write ignored", STAT_A, 32'h2000_0000);
    chk("summary irq", {31'h0, irq}, 32'h1);
    shi <= 16'h0;
  endtask

  task automatic t_gates;
    int hb [6] = '{30, 25, 24, 23, 21, 20};
    for (int k = 0; k < 6; k++) begin
      bus_wr(MASK_A, 32'h1 << hb[k], '0);
      shi <= 16'h1 << (hb[k] - 16);
      repeat (3) @(posedge mclk);
      chk("enabled upper bit irq", {31'h0, irq}, 32'h1);
      shi <= ~(16'h1 << (hb[k] - 16));
      repeat (3) @(posedge mclk);
      chk("other upper bits no irq", {31'h0, irq}, 32'h0);
    end
    shi <= 16'h0;
    bus_wr(MASK_A, 32'h0, '0);
  endtask

  task automatic t_rerun_reset;
    ev_pulse(metro_evt_t'(8'hff), '0);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    rd_chk("status after reset", STAT_A, 32'h0);
    rd_chk("mask after reset", MASK_A, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_power();
    t_pins();
    t_irq();
    t_gates();
    t_rerun_reset();
    stop_test();
  end

  // Whole run is a few hundred cycles, so this span only trips on a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
